// File: core/usb_nak_stall_ctrl.sv
`timescale 1ns/100ps
`include "usb_nak_regs.svh"

module usb_nak_stall_ctrl (
  // clock and reset
  input  wire logic                   sys_clk_in,
  input  wire logic                   rstn_in,
  // avalon-mm slave
  input  wire logic [`NAK_ADDR_W-1:0] address_in,
  input  wire logic                   read_in,
  input  wire logic                   write_in,
  input  wire logic [31:0]            writedata_in,
  input  wire logic [3:0]             byteenable_in,
  output logic      [31:0]            readdata_out,
  output logic                        waitrequest_out,
  // serial engine events, same clock
  input  wire logic                   setup_token_in,
  input  wire logic                   ep0_rx_ok_in,
  input  wire logic                   ep0_tx_ok_in,
  input  wire logic                   ep0_rx_drained_in,
  input  wire logic                   ctrl_done_in,
  input  wire logic                   nak_active_in,
  input  wire logic [4:0]             cf_done_in,
  // fifo status, same clock
  input  wire logic                   bulk_se_bank_valid_in,
  input  wire logic                   bulk_cpu_count_zero_in,
  input  wire logic                   bulk_in_nak_in,
  input  wire logic                   intr_in_nak_set_in,
  input  wire logic [2:0]             ep_enable_in,
  // handshake selection
  output usb_nak_pkg::hs_e            ep0_in_hs_out,
  output usb_nak_pkg::hs_e            ep0_out_hs_out,
  output usb_nak_pkg::hs_e            bulk_out_hs_out,
  output logic                        ep0_tx_send_out,
  // fifo and bus control
  output logic                        bulk_swap_out,
  output logic [3:0]                  fifo_clear_out,
  output logic                        setup_capture_out,
  output logic                        resume_out
);
  import usb_nak_pkg::*;

  // ****************************************
  // helpers
  // ****************************************

  // stall beats nak beats ack
  function automatic hs_e pick_hs(input logic stall, input logic nak);
    if (stall) begin
      return HS_STALL;
    end else if (nak) begin
      return HS_NAK;
    end
    return HS_ACK;
  endfunction

  // a write hits a register only with its byte lane enabled
  function automatic logic hit(input logic [`NAK_ADDR_W-1:0] a, input logic [`NAK_ADDR_W-1:0] off,
                               input logic strobe, input logic lane);
    return strobe & lane & (a == off);
  endfunction

  // ****************************************
  // bus port
  // ****************************************
  reg_access_if acc ();

  avalon_reg_port u_port (
    .sys_clk_in      (sys_clk_in),
    .rstn_in         (rstn_in),
    .address_in      (address_in),
    .read_in         (read_in),
    .write_in        (write_in),
    .writedata_in    (writedata_in),
    .byteenable_in   (byteenable_in),
    .readdata_out    (readdata_out),
    .waitrequest_out (waitrequest_out),
    .acc             (acc)
  );

  // ****************************************
  // state
  // ****************************************
  logic       ep0_rx_nak_q,    ep0_rx_nak_d;
  logic       ep0_tx_nak_q,    ep0_tx_nak_d;
  logic       ep0_nak_all_q,   ep0_nak_all_d;
  logic       bulk_hw_nak_q,   bulk_hw_nak_d;
  logic       bulk_sw_nak_q,   bulk_sw_nak_d;
  logic       intr_in_nak_q,   intr_in_nak_d;
  logic       bulk_we_q,       bulk_we_d;
  logic       force_stall_q,   force_stall_d;
  logic       resume_q,        resume_d;
  logic       rwe_q,           rwe_d;
  logic       overrun_q,       overrun_d;
  logic       ctrl_busy_q,     ctrl_busy_d;
  logic [4:0] cf_q,            cf_d;
  logic [4:0] cf_seen_q;
  logic       swap_q;
  logic [3:0] fifo_clear_q;
  logic       setup_cap_q;

  // ****************************************
  // write decode
  // ****************************************
  wire wr_ep0_nak  = hit(acc.addr, `OFF_EP0_NAK,      acc.wr, acc.lane0);
  wire wr_nak_all  = hit(acc.addr, `OFF_EP0_NAK_ALL,  acc.wr, acc.lane0);
  wire wr_ep_nak   = hit(acc.addr, `OFF_EP_NAK,       acc.wr, acc.lane0);
  wire wr_mask     = hit(acc.addr, `OFF_EP_NAK_MASK,  acc.wr, acc.lane0);
  wire wr_engine   = hit(acc.addr, `OFF_ENGINE_CTRL,  acc.wr, acc.lane0);
  wire wr_fc0      = hit(acc.addr, `OFF_FIFO_CLEAR0,  acc.wr, acc.lane0);
  wire wr_fc1      = hit(acc.addr, `OFF_FIFO_CLEAR1,  acc.wr, acc.lane0);
  wire wr_iclr1    = hit(acc.addr, `OFF_INTR_CLEAR1,  acc.wr, acc.lane0);
  wire wr_dend     = hit(acc.addr, `OFF_DATA_END,     acc.wr, acc.lane0);
  wire wr_devstate = hit(acc.addr, `OFF_DEVICE_STATE, acc.wr, acc.lane0);
  wire rd_cf       = acc.rd & (acc.addr == `OFF_CLR_FEATURE);
  wire rd_cf_early = acc.rd_early & (acc.addr == `OFF_CLR_FEATURE);

  // ****************************************
  // fifo clear strobes and their delayed effect
  // ****************************************
  wire [3:0] fc_req = {wr_fc1 & acc.wdata[`B_FC1_INTR_IN],
                       wr_fc1 & acc.wdata[`B_FC1_BULK_OUT],
                       wr_fc0 & acc.wdata[`B_FC0_EP0_TX],
                       wr_fc0 & acc.wdata[`B_FC0_EP0_RX]};
  logic [3:0] fc_late;

  // the nak bits follow the fifo clear only once the fifo itself has settled
  fifo_clear_delay #(
    .DEPTH (`FIFO_CLEAR_DELAY),
    .WIDTH (4)
  ) u_fc_delay (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .pulse_in   (fc_req),
    .pulse_out  (fc_late)
  );

  wire clr_ep0_rx = fc_late[0];
  wire clr_ep0_tx = fc_late[1];
  wire clr_bulk   = fc_late[2];
  wire clr_intr   = fc_late[3];

  // ****************************************
  // endpoint 0 nak and overrun
  // ****************************************
  // writes to the rx nak bit are dropped while a nak is on the wire
  wire ep0_rx_sw_ok = wr_ep0_nak & ~nak_active_in;
  wire setup_over   = setup_token_in & ctrl_busy_q;

  always_comb begin
    // hardware set wins over every clear
    ep0_rx_nak_d = ep0_rx_nak_q;
    if (ep0_rx_sw_ok) begin
      ep0_rx_nak_d = acc.wdata[`B_EP0_RX_NAK];
    end
    if (clr_ep0_rx | ep0_rx_drained_in) begin
      ep0_rx_nak_d = 1'b0;
    end
    if (ep0_rx_ok_in) begin
      ep0_rx_nak_d = 1'b1;
    end
  end

  always_comb begin
    // software can only arm the send through the tx done bit
    ep0_tx_nak_d = ep0_tx_nak_q;
    if (ep0_tx_ok_in | clr_ep0_tx) begin
      ep0_tx_nak_d = 1'b0;
    end
    if (wr_dend & acc.wdata[`B_EP0_TX_DONE]) begin
      ep0_tx_nak_d = 1'b1;
    end
  end

  always_comb begin
    // firmware clears the flag by writing zero; a new setup still wins
    overrun_d = overrun_q;
    if (wr_iclr1 & ~acc.wdata[`B_SETUP_OVERRUN]) begin
      overrun_d = 1'b0;
    end
    if (setup_over) begin
      overrun_d = 1'b1;
    end
    ctrl_busy_d = ctrl_busy_q;
    if (ctrl_done_in) begin
      ctrl_busy_d = 1'b0;
    end
    if (setup_token_in) begin
      ctrl_busy_d = 1'b1;
    end
  end

  // nak all and force stall are plain software bits, stall ends at setup
  assign ep0_nak_all_d = wr_nak_all ? acc.wdata[`B_EP0_NAK_ALL] : ep0_nak_all_q;
  assign force_stall_d = wr_engine ? acc.wdata[`B_FORCE_STALL]
                       : (setup_token_in ? 1'b0 : force_stall_q);

  // ****************************************
  // bulk out and interrupt in
  // ****************************************
  // bank swap needs fresh data on the engine side and an empty cpu bank
  wire swap_now  = bulk_se_bank_valid_in & bulk_cpu_count_zero_in & ~swap_q;
  wire bank_full = bulk_se_bank_valid_in & ~bulk_cpu_count_zero_in;
  wire bulk_sw_ok = wr_ep_nak & bulk_we_q & ~nak_active_in;

  always_comb begin
    // the hardware part and the firmware part are kept apart so that a
    // fifo clear cannot undo a nak that firmware asked for
    bulk_hw_nak_d = bulk_hw_nak_q;
    if (swap_now | clr_bulk) begin
      bulk_hw_nak_d = 1'b0;
    end
    if (bank_full) begin
      bulk_hw_nak_d = 1'b1;
    end
    bulk_sw_nak_d = bulk_sw_ok ? acc.wdata[`B_BULK_OUT_NAK] : bulk_sw_nak_q;
  end

  always_comb begin
    intr_in_nak_d = intr_in_nak_q;
    if (clr_intr) begin
      intr_in_nak_d = 1'b0;
    end
    if (intr_in_nak_set_in) begin
      intr_in_nak_d = 1'b1;
    end
  end

  assign bulk_we_d = wr_mask ? acc.wdata[`B_BULK_OUT_NAK_WE] : bulk_we_q;

  // ****************************************
  // resume and device state
  // ****************************************
  assign rwe_d    = wr_devstate ? acc.wdata[`B_REMOTE_WAKEUP] : rwe_q;
  assign resume_d = (wr_engine & rwe_q) ? acc.wdata[`B_RESUME_DRIVE] : resume_q;

  // ****************************************
  // clear feature flags
  // ****************************************
  // only the bits seen by the read are cleared, so a late event survives
  assign cf_d = (cf_q & ~(rd_cf ? cf_seen_q : `RST_CF)) | cf_done_in;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ep0_rx_nak_q  <= 1'b0;
      ep0_tx_nak_q  <= 1'b0;
      ep0_nak_all_q <= 1'b0;
      bulk_hw_nak_q <= 1'b0;
      bulk_sw_nak_q <= 1'b0;
      intr_in_nak_q <= 1'b0;
      bulk_we_q     <= 1'b0;
      force_stall_q <= 1'b0;
      resume_q      <= 1'b0;
      rwe_q         <= 1'b0;
      overrun_q     <= 1'b0;
      ctrl_busy_q   <= 1'b0;
      cf_q          <= `RST_CF;
    end else begin
      ep0_rx_nak_q  <= ep0_rx_nak_d;
      ep0_tx_nak_q  <= ep0_tx_nak_d;
      ep0_nak_all_q <= ep0_nak_all_d;
      bulk_hw_nak_q <= bulk_hw_nak_d;
      bulk_sw_nak_q <= bulk_sw_nak_d;
      intr_in_nak_q <= intr_in_nak_d;
      bulk_we_q     <= bulk_we_d;
      force_stall_q <= force_stall_d;
      resume_q      <= resume_d;
      rwe_q         <= rwe_d;
      overrun_q     <= overrun_d;
      ctrl_busy_q   <= ctrl_busy_d;
      cf_q          <= cf_d;
    end
  end

  // strobes to the fifo side and the read snapshot
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cf_seen_q    <= `RST_CF;
      swap_q       <= 1'b0;
      fifo_clear_q <= 4'h0;
      setup_cap_q  <= 1'b0;
    end else begin
      cf_seen_q    <= rd_cf_early ? cf_q : cf_seen_q;
      swap_q       <= swap_now;
      fifo_clear_q <= fc_req;
      setup_cap_q  <= setup_token_in;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  wire       bulk_out_nak = bulk_hw_nak_q | bulk_sw_nak_q;
  wire [7:0] ep0_nak_rd;
  wire [7:0] ep_nak_rd;
  wire [7:0] cf_rd;
  // every image is built from single bits, so reserved positions read as zero

  // a bit shows a value only at its own position, the rest read as zero
  function automatic logic [7:0] at_bit(input logic v, input int pos);
    logic [7:0] r;
    r = 8'h00;
    r[pos[2:0]] = v;
    return r;
  endfunction

  assign ep0_nak_rd = at_bit(ep0_rx_nak_q, `B_EP0_RX_NAK) | at_bit(ep0_tx_nak_q, `B_EP0_TX_NAK);
  // disabled endpoints report nothing
  assign ep_nak_rd  = at_bit(intr_in_nak_q & ep_enable_in[0], `B_INTR_IN_NAK)
                    | at_bit(bulk_out_nak & ep_enable_in[1], `B_BULK_OUT_NAK)
                    | at_bit(bulk_in_nak_in & ep_enable_in[0], `B_BULK_IN_NAK);
  assign cf_rd      = at_bit(cf_q[0], `B_CF_DEV) | at_bit(cf_q[1], `B_CF_EP0)
                    | at_bit(cf_q[2] & ep_enable_in[0], `B_CF_EP1)
                    | at_bit(cf_q[3] & ep_enable_in[1], `B_CF_EP2)
                    | at_bit(cf_q[4] & ep_enable_in[2], `B_CF_EP7);

  always_comb begin
    // unmapped addresses and write-only registers read as zero
    if (acc.addr == `OFF_EP0_NAK) begin
      acc.rdata = ep0_nak_rd;
    end else if (acc.addr == `OFF_EP0_NAK_ALL) begin
      acc.rdata = at_bit(ep0_nak_all_q, `B_EP0_NAK_ALL);
    end else if (acc.addr == `OFF_EP_NAK) begin
      acc.rdata = ep_nak_rd;
    end else if (acc.addr == `OFF_EP_NAK_MASK) begin
      acc.rdata = at_bit(bulk_we_q, `B_BULK_OUT_NAK_WE);
    end else if (acc.addr == `OFF_ENGINE_CTRL) begin
      acc.rdata = at_bit(force_stall_q, `B_FORCE_STALL) | at_bit(resume_q, `B_RESUME_DRIVE);
    end else if (acc.addr == `OFF_CLR_FEATURE) begin
      acc.rdata = cf_rd;
    end else if (acc.addr == `OFF_INTR_STATUS1) begin
      acc.rdata = at_bit(overrun_q, `B_SETUP_OVERRUN);
    end else if (acc.addr == `OFF_DEVICE_STATE) begin
      acc.rdata = at_bit(rwe_q, `B_REMOTE_WAKEUP);
    end else begin
      acc.rdata = `RST_BYTE;
    end
  end

  // ****************************************
  // handshake outputs
  // ****************************************
  // nak all covers automatic requests too; setup is never gated here
  wire ep0_block = ep0_nak_all_q;

  assign ep0_in_hs_out   = pick_hs(force_stall_q, ep0_block | ~ep0_tx_nak_q);
  assign ep0_out_hs_out  = pick_hs(force_stall_q, ep0_block | ep0_rx_nak_q);
  assign bulk_out_hs_out = pick_hs(1'b0, bulk_out_nak);
  assign ep0_tx_send_out = ep0_tx_nak_q & ~ep0_block & ~force_stall_q;
  assign bulk_swap_out     = swap_q;
  assign fifo_clear_out    = fifo_clear_q;
  assign setup_capture_out = setup_cap_q;
  assign resume_out        = resume_q;
endmodule

// File: core/usb_nak_regs.svh
`ifndef USB_NAK_REGS_SVH
`define USB_NAK_REGS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define NAK_ADDR_W         16
`define OFF_EP0_NAK        16'h4000
`define OFF_EP0_NAK_ALL    16'h4004
`define OFF_EP_NAK         16'h4008
`define OFF_EP_NAK_MASK    16'h400c
`define OFF_ENGINE_CTRL    16'h4010
`define OFF_CLR_FEATURE    16'h4014
`define OFF_FIFO_CLEAR0    16'h4030
`define OFF_FIFO_CLEAR1    16'h4034
`define OFF_INTR_STATUS1   16'h4040
`define OFF_INTR_CLEAR1    16'h4044
`define OFF_DATA_END       16'h4048
`define OFF_DEVICE_STATE   16'h4050

// ****************************************
// field positions
// ****************************************
`define B_EP0_TX_NAK       0
`define B_EP0_RX_NAK       1
`define B_EP0_NAK_ALL      0
`define B_BULK_IN_NAK      0
`define B_BULK_OUT_NAK     2
`define B_INTR_IN_NAK      4
`define B_BULK_OUT_NAK_WE  2
`define B_RESUME_DRIVE     0
`define B_FORCE_STALL      3
`define B_CF_DEV           0
`define B_CF_EP0           1
`define B_CF_EP1           2
`define B_CF_EP2           3
`define B_CF_EP7           6
`define B_FC0_EP0_RX       0
`define B_FC0_EP0_TX       1
`define B_FC1_BULK_OUT     0
`define B_FC1_INTR_IN      1
`define B_SETUP_OVERRUN    0
`define B_EP0_TX_DONE      0
`define B_REMOTE_WAKEUP    0

// ****************************************
// reset values and timing
// ****************************************
`define RST_BYTE           8'h00
`define RST_CF             5'h00
`define FIFO_CLEAR_DELAY   5

`endif

// File: core/usb_nak_pkg.sv
package usb_nak_pkg;
  // handshake that the serial engine returns to a token
  typedef enum logic [1:0] {
    HS_ACK,
    HS_NAK,
    HS_STALL
  } hs_e;

  typedef logic [7:0] byte_t;
endpackage

// File: core/reg_access_if.sv
`timescale 1ns/100ps
`include "usb_nak_regs.svh"

// register access strobes between the bus port and the register bank
interface reg_access_if;
  logic [`NAK_ADDR_W-1:0] addr;
  logic [7:0]             wdata;
  logic                   lane0;
  logic                   wr;
  logic                   rd;
  logic                   rd_early;
  logic [7:0]             rdata;

  modport port (output addr, output wdata, output lane0, output wr, output rd, output rd_early, input rdata);
  modport bank (input addr, input wdata, input lane0, input wr, input rd, input rd_early, output rdata);
endinterface

// File: core/avalon_reg_port.sv
`timescale 1ns/100ps
`include "usb_nak_regs.svh"

module avalon_reg_port (
  // clock and reset
  input  wire logic                   sys_clk_in,
  input  wire logic                   rstn_in,
  // avalon-mm slave
  input  wire logic [`NAK_ADDR_W-1:0] address_in,
  input  wire logic                   read_in,
  input  wire logic                   write_in,
  input  wire logic [31:0]            writedata_in,
  input  wire logic [3:0]             byteenable_in,
  output logic      [31:0]            readdata_out,
  output logic                        waitrequest_out,
  // register bank side
  reg_access_if.port                  acc
);
  logic       ack_q;
  logic [7:0] rdata_q;
  wire        req = read_in | write_in;

  // one wait state: data is captured first, then the access completes
  assign waitrequest_out = req & ~ack_q;
  assign acc.addr        = address_in;
  assign acc.wdata       = writedata_in[7:0];
  assign acc.lane0       = byteenable_in[0];
  assign acc.wr          = write_in & ack_q;
  assign acc.rd          = read_in & ack_q;
  assign acc.rd_early    = read_in & ~ack_q;
  assign readdata_out    = {24'h000000, rdata_q};

  // ack toggles off after every completed access, so back to back works
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_q   <= 1'b0;
      rdata_q <= `RST_BYTE;
    end else begin
      ack_q <= req & ~ack_q;
      if (acc.rd_early) begin
        rdata_q <= acc.rdata;
      end
    end
  end
endmodule

// File: core/fifo_clear_delay.sv
`timescale 1ns/100ps
`include "usb_nak_regs.svh"

module fifo_clear_delay #(
  parameter int DEPTH = `FIFO_CLEAR_DELAY,
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rstn_in,
  // clear pulses in and delayed out
  input  wire logic [WIDTH-1:0] pulse_in,
  output logic      [WIDTH-1:0] pulse_out
);
  // the consumer registers the result, so DEPTH-1 stages here give DEPTH edges
  logic [WIDTH-1:0] stage_q [DEPTH-1];

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < DEPTH-1; i++) begin
        stage_q[i] <= '0;
      end
    end else begin
      stage_q[0] <= pulse_in;
      for (int i = 1; i < DEPTH-1; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign pulse_out = stage_q[DEPTH-2];
endmodule

// File: tb/usb_host_model.sv
`timescale 1ns/100ps
// ****************************************
// usb host side: tokens and data acks
// ****************************************
module usb_host_model import usb_nak_pkg::*; (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rstn_in,
  // token order: 1 setup, 2 out, 3 in
  input  wire logic [1:0]       tok_in,
  input  wire usb_nak_pkg::hs_e in_hs_in,
  input  wire usb_nak_pkg::hs_e out_hs_in,
  // engine event pulses
  output logic                  setup_out,
  output logic                  rx_ok_out,
  output logic                  tx_ok_out
);
  import usb_nak_pkg::*;
  // data only lands when the device answered ack, as a real host sees it
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      setup_out <= 1'b0;
      rx_ok_out <= 1'b0;
      tx_ok_out <= 1'b0;
    end else begin
      setup_out <= tok_in == 2'h1;
      rx_ok_out <= tok_in == 2'h2 && out_hs_in == HS_ACK;
      tx_ok_out <= tok_in == 2'h3 && in_hs_in == HS_ACK;
    end
  end
endmodule

// File: tb/usb_nak_stall_ctrl_properties.sv
`timescale 1ns/100ps
`include "usb_nak_regs.svh"
// ****************************************
// port checker
// ****************************************
module usb_nak_stall_ctrl_properties import usb_nak_pkg::*; (
  // clock, reset, bus
  input wire logic                   sys_clk_in,
  input wire logic                   rstn_in,
  input wire logic [`NAK_ADDR_W-1:0] address_in,
  input wire logic                   write_in,
  input wire logic [31:0]            writedata_in,
  input wire logic [3:0]             byteenable_in,
  input wire logic                   waitrequest_out,
  // events and handshakes
  input wire logic                   setup_token_in,
  input wire logic                   bulk_se_bank_valid_in,
  input wire logic                   bulk_cpu_count_zero_in,
  input wire usb_nak_pkg::hs_e       ep0_in_hs_out,
  input wire usb_nak_pkg::hs_e       ep0_out_hs_out,
  input wire usb_nak_pkg::hs_e       bulk_out_hs_out,
  input wire logic                   ep0_tx_send_out,
  input wire logic                   bulk_swap_out,
  input wire logic [3:0]             fifo_clear_out,
  input wire logic                   setup_capture_out,
  input wire logic                   resume_out
);
  import usb_nak_pkg::*;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // completed writes, mirrored so handshakes can be tied to register state
  logic wdone;
  logic fc_bulk;
  logic wr_eng;
  logic na_q;
  logic rw_q;
  assign wdone   = write_in && !waitrequest_out && byteenable_in[0];
  assign fc_bulk = wdone && address_in == `OFF_FIFO_CLEAR1 && writedata_in[0];
  assign wr_eng  = wdone && address_in == `OFF_ENGINE_CTRL;
  // shadow of nak-all and remote wakeup bits
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      na_q <= 1'b0;
      rw_q <= 1'b0;
    end else if (wdone) begin
      if (address_in == `OFF_EP0_NAK_ALL) na_q <= writedata_in[0];
      if (address_in == `OFF_DEVICE_STATE) rw_q <= writedata_in[0];
    end
  end
  sequence s_one_pulse; fifo_clear_out[2] ##1 !fifo_clear_out[2]; endsequence
  property p_fc_pulse; fc_bulk |=> s_one_pulse; endproperty
  property p_capture; setup_token_in |=> setup_capture_out; endproperty
  property p_swap; bulk_swap_out |-> $past(bulk_se_bank_valid_in) && $past(bulk_cpu_count_zero_in); endproperty
  property p_bulk_nak; bulk_se_bank_valid_in && !bulk_cpu_count_zero_in |=> bulk_out_hs_out == HS_NAK; endproperty
  property p_tx_send; ep0_tx_send_out |-> ep0_in_hs_out == HS_ACK; endproperty
  property p_nak_all; na_q |-> ep0_in_hs_out != HS_ACK && ep0_out_hs_out != HS_ACK; endproperty
  property p_resume_rw; $rose(resume_out) |-> rw_q; endproperty
  property p_resume_hold; $fell(resume_out) |-> $past(wr_eng) || $past(wr_eng, 2); endproperty
  a_fc_pulse: assert property (p_fc_pulse) else $error("fifo clear pulse missing");
  a_capture: assert property (p_capture) else $error("setup capture missing");
  a_swap: assert property (p_swap) else $error("bank swap without cause");
  a_bulk_nak: assert property (p_bulk_nak) else $error("bulk nak not set on full bank");
  a_tx_send: assert property (p_tx_send) else $error("ep0 send while not ack");
  a_nak_all: assert property (p_nak_all) else $error("ep0 ack while nak all");
  a_resume_rw: assert property (p_resume_rw) else $error("resume without wakeup enable");
  a_resume_hold: assert property (p_resume_hold) else $error("resume dropped by itself");
endmodule

bind usb_nak_stall_ctrl usb_nak_stall_ctrl_properties u_usb_nak_stall_ctrl_properties (.*);

// File: tb/usb_nak_stall_ctrl_tb.sv
`timescale 1ns/100ps
module usb_nak_stall_ctrl_tb;
  import usb_nak_pkg::*;
  logic sys_clk_in = 0, rstn_in = 0, read_in = 0, write_in = 0, waitrequest_out, ctrl_done_in = 0;
  logic ep0_rx_drained_in = 0, nak_active_in = 0, bulk_se_bank_valid_in = 0, bulk_cpu_count_zero_in = 0;
  logic bulk_in_nak_in = 0, intr_in_nak_set_in = 0, setup_token_in, ep0_rx_ok_in, ep0_tx_ok_in;
  logic ep0_tx_send_out, bulk_swap_out, setup_capture_out, resume_out;
  logic [15:0] address_in = 0;
  logic [31:0] writedata_in = 0, readdata_out;
  logic [3:0] byteenable_in = 4'h1, fifo_clear_out;
  logic [4:0] cf_done_in = 0;
  logic [2:0] ep_enable_in = 3'h7;
  logic [1:0] tok = 0;
  hs_e ep0_in_hs_out, ep0_out_hs_out, bulk_out_hs_out;
  int err_total = 0, num_checks = 0;
  always #25 sys_clk_in = ~sys_clk_in;
  usb_nak_stall_ctrl u_usb_nak_stall_ctrl (.*);
  usb_host_model u_usb_host_model (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .tok_in(tok),
    .in_hs_in(ep0_in_hs_out), .out_hs_in(ep0_out_hs_out), .setup_out(setup_token_in),
    .rx_ok_out(ep0_rx_ok_in), .tx_ok_out(ep0_tx_ok_in));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one avalon cycle; request held until the rising edge that sees waitrequest low
  task automatic bus(logic w, logic [15:0] a, logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge sys_clk_in);
    address_in <= a;
    writedata_in <= {24'h0, d};
    write_in <= w;
    read_in <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk_in);
      if (waitrequest_out === 1'b0) break;
    end
    if (n == 20) begin
      err_total++;
      end_of_test();
    end
    q = readdata_out[7:0];
    write_in <= 0;
    read_in <= 0;
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    logic [7:0] q;
    bus(1, a, d, q);
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    logic [7:0] q;
    bus(0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic host(logic [1:0] t);
    @(posedge sys_clk_in) tok <= t;
    @(posedge sys_clk_in) tok <= 0;
    repeat (2) @(posedge sys_clk_in);
  endtask
  task automatic hs(hs_e ei, hs_e eo, hs_e eb);
    @(posedge sys_clk_in);
    chk("ep0 in hs", 8'(ei), 8'(ep0_in_hs_out));
    chk("ep0 out hs", 8'(eo), 8'(ep0_out_hs_out));
    chk("bulk hs", 8'(eb), 8'(bulk_out_hs_out));
  endtask
  initial begin
    int i;
    repeat (5) @(posedge sys_clk_in);
    rstn_in <= 1;
    for (i = 0; i < 6; i++) rd(16'h4000 + 16'(i * 4), 8'h00);
    hs(HS_NAK, HS_ACK, HS_ACK);
    wr(16'h4100, 8'hff); rd(16'h4100, 8'h00);
    $display("reset test done");
    wr(16'h4000, 8'h03); rd(16'h4000, 8'h02);
    nak_active_in <= 1; wr(16'h4000, 8'h00); rd(16'h4000, 8'h02);
    nak_active_in <= 0; @(posedge sys_clk_in) ep0_rx_drained_in <= 1;
    @(posedge sys_clk_in) ep0_rx_drained_in <= 0; rd(16'h4000, 8'h00);
    host(2'h2); rd(16'h4000, 8'h02); wr(16'h4030, 8'h01); repeat (4) @(posedge sys_clk_in);
    rd(16'h4000, 8'h00);
    $display("ep0 rx test done");
    wr(16'h4008, 8'h04); rd(16'h4008, 8'h00);
    wr(16'h400c, 8'h04); wr(16'h4008, 8'h04); rd(16'h4008, 8'h04);
    nak_active_in <= 1; wr(16'h4008, 8'h00); rd(16'h4008, 8'h04);
    nak_active_in <= 0; wr(16'h4034, 8'h01); repeat (4) @(posedge sys_clk_in);
    rd(16'h4008, 8'h04); wr(16'h4008, 8'h00); rd(16'h4008, 8'h00);
    bulk_se_bank_valid_in <= 1; repeat (2) @(posedge sys_clk_in); hs(HS_NAK, HS_ACK, HS_NAK);
    bulk_se_bank_valid_in <= 0; wr(16'h4034, 8'h01); repeat (5) @(posedge sys_clk_in);
    hs(HS_NAK, HS_ACK, HS_ACK);
    bulk_se_bank_valid_in <= 1; bulk_cpu_count_zero_in <= 1;
    for (i = 0; i < 10; i++) begin
      @(posedge sys_clk_in);
      if (bulk_swap_out === 1'b1) break;
    end
    chk("bank swap", 8'h01, 8'(i < 10));
    bulk_se_bank_valid_in <= 0; bulk_cpu_count_zero_in <= 0; bulk_in_nak_in <= 1;
    @(posedge sys_clk_in) intr_in_nak_set_in <= 1; @(posedge sys_clk_in) intr_in_nak_set_in <= 0;
    rd(16'h4008, 8'h11); ep_enable_in <= 3'h6; rd(16'h4008, 8'h00); ep_enable_in <= 3'h7;
    bulk_in_nak_in <= 0; wr(16'h4034, 8'h02); repeat (4) @(posedge sys_clk_in); rd(16'h4008, 8'h00);
    $display("bulk test done");
    rd(16'h4040, 8'h00); wr(16'h4048, 8'h01); rd(16'h4000, 8'h01); hs(HS_ACK, HS_ACK, HS_ACK);
    chk("tx send", 8'h01, 8'(ep0_tx_send_out)); host(2'h3); rd(16'h4000, 8'h00);
    wr(16'h4004, 8'h01); rd(16'h4004, 8'h01); wr(16'h4048, 8'h01); hs(HS_NAK, HS_NAK, HS_ACK);
    host(2'h3); rd(16'h4000, 8'h01); wr(16'h4004, 8'h00); host(2'h3); rd(16'h4000, 8'h00);
    host(2'h1); host(2'h1); rd(16'h4040, 8'h01); wr(16'h4044, 8'h00); rd(16'h4040, 8'h00);
    @(posedge sys_clk_in) ctrl_done_in <= 1; @(posedge sys_clk_in) ctrl_done_in <= 0;
    wr(16'h4010, 8'h08); rd(16'h4010, 8'h08); hs(HS_STALL, HS_STALL, HS_ACK);
    host(2'h1); rd(16'h4010, 8'h00);
    $display("ep0 test done");
    wr(16'h4010, 8'h01); rd(16'h4010, 8'h00);
    wr(16'h4050, 8'h01); wr(16'h4010, 8'h01); repeat (20) @(posedge sys_clk_in);
    chk("resume", 8'h01, 8'(resume_out)); wr(16'h4010, 8'h00); rd(16'h4010, 8'h00);
    @(posedge sys_clk_in) cf_done_in <= 5'h1f; @(posedge sys_clk_in) cf_done_in <= 0;
    rd(16'h4014, 8'h4f); rd(16'h4014, 8'h00); ep_enable_in <= 3'h0;
    @(posedge sys_clk_in) cf_done_in <= 5'h1f; @(posedge sys_clk_in) cf_done_in <= 0;
    rd(16'h4014, 8'h03);
    $display("resume and clear feature test done");
    end_of_test();
  end
endmodule
